// ### rtl/plp_core.v
// pci lock tracking, parity checking, error and interrupt pins, apb registers
`timescale 1ns/1ps
`include "plp_consts.vh"
module plp_core (
	// clock and reset
	input  wire        core_clk_in,
	input  wire        reset_in,
	// apb slave
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [11:0] paddr_in,
	input  wire [31:0] pwdata_in,
	output reg  [31:0] prdata_out,
	output reg         pready_out,
	output reg         pslverr_out,
	// pci pins sampled from the bus, active low where named _n
	input  wire [31:0] ad_in,
	input  wire [3:0]  cbe_n_in,
	input  wire        par_in,
	input  wire        frame_n_in,
	input  wire        irdy_n_in,
	input  wire        trdy_n_in,
	input  wire        stop_n_in,
	input  wire        devsel_n_in,
	input  wire        lock_n_in,
	// transaction context from the surrounding controller
	input  wire        target_sel_in,
	input  wire        target_write_in,
	input  wire        master_active_in,
	input  wire        master_read_in,
	input  wire        int_event_in,
	// pci driver controls
	output reg         inta_n_oe_out,
	output reg         serr_n_oe_out,
	output reg         perr_n_out,
	output reg         perr_n_oe_out,
	output reg         lock_n_oe_out,
	// status to the surrounding controller
	output reg         target_retry_out,
	output reg         master_retry_out,
	output reg         locked_out,
	output reg         irq_out
);
	localparam ST_UNLOCKED = 2'b01;
	localparam ST_LOCKED   = 2'b10;
	localparam SW = 43;
	////////////////////////////////////////////////////////////////////////
	// two-stage synchroniser on every bus input
	reg [SW-1:0] sync1;
	reg [SW-1:0] sync2;
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			sync1 <= {SW{1'b1}};
			sync2 <= {SW{1'b1}};
		end else begin
			sync1 <= {ad_in, cbe_n_in, par_in, frame_n_in, irdy_n_in, trdy_n_in,
				stop_n_in, devsel_n_in, lock_n_in};
			sync2 <= sync1;
		end
	end
	wire [31:0] s_ad     = sync2[42:11];
	wire [3:0]  s_cbe_n  = sync2[10:7];
	wire        s_par    = sync2[6];
	wire        s_frame  = ~sync2[5];
	wire        s_irdy   = ~sync2[4];
	wire        s_trdy   = ~sync2[3];
	wire        s_stop   = ~sync2[2];
	wire        s_devsel = ~sync2[1];
	wire        s_lock   = ~sync2[0];
	////////////////////////////////////////////////////////////////////////
	// bus phase tracking
	reg        frame_d;
	reg        busy;
	reg [3:0]  cmd_cap;
	wire       frame_start = s_frame & ~frame_d & ~busy;
	wire       xfer        = s_irdy & s_trdy;
	wire       last_xfer   = xfer & ~s_frame;
	wire       special     = (frame_start ? s_cbe_n : cmd_cap) == `PLP_SPECIAL_CYCLE;
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			frame_d <= 1'b0;
			busy    <= 1'b0;
			cmd_cap <= 4'h0;
		end else begin
			frame_d <= s_frame;
			if (frame_start)
				cmd_cap <= s_cbe_n;
			// the transaction ends once frame and irdy are both released
			busy <= s_frame | s_irdy;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// registers
	reg [15:0]           cmd_reg;
	reg [15:0]           stat_reg;
	reg                  icsr_src;
	reg                  icsr_en;
	reg [`PLP_EVT_W-1:0] evt_reg;
	reg [`PLP_EVT_W-1:0] mask_reg;
	wire perr_en = cmd_reg[`PLP_CMD_PERR_EN];
	wire serr_en = cmd_reg[`PLP_CMD_SERR_EN];
	////////////////////////////////////////////////////////////////////////
	// parity checking
	reg  addr_chk;
	reg  addr_par;
	reg  data_chk;
	reg  data_par;
	reg  data_master;
	reg  data_special;
	reg  rx_d;
	wire receiving  = (target_sel_in & target_write_in) | (master_active_in & master_read_in);
	wire addr_err   = addr_chk & (addr_par ^ s_par);
	wire data_err   = data_chk & (data_par ^ s_par);
	wire serr_fire  = addr_err & serr_en;
	wire perr_fire  = data_err & perr_en & ~data_special;
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			addr_chk     <= 1'b0;
			addr_par     <= 1'b0;
			data_chk     <= 1'b0;
			data_par     <= 1'b0;
			data_master  <= 1'b0;
			data_special <= 1'b0;
			rx_d         <= 1'b0;
			serr_n_oe_out <= 1'b0;
			perr_n_out    <= 1'b1;
			perr_n_oe_out <= 1'b0;
		end else begin
			// address and command from the frame clock, par from the next
			addr_chk <= frame_start;
			addr_par <= ^{s_ad, s_cbe_n};
			data_chk <= xfer & receiving & ~frame_start;
			data_par <= ^{s_ad, s_cbe_n};
			data_master  <= master_active_in;
			data_special <= special;
			rx_d <= receiving;
			serr_n_oe_out <= serr_fire;
			// perr stays enabled for the two clocks after the last received word
			perr_n_oe_out <= receiving | rx_d | data_chk;
			perr_n_out    <= ~perr_fire;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// target lock state
	reg [1:0] lock_state;
	reg       start_pend;
	reg       start_lock_free;
	reg       owner_access;
	reg       unlock_pend;
	reg       retry_evt;
	reg       lock_evt;
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			lock_state       <= ST_UNLOCKED;
			start_pend       <= 1'b0;
			start_lock_free  <= 1'b0;
			owner_access     <= 1'b0;
			unlock_pend      <= 1'b0;
			target_retry_out <= 1'b0;
			locked_out       <= 1'b0;
			retry_evt        <= 1'b0;
			lock_evt         <= 1'b0;
		end else begin
			start_pend  <= frame_start;
			lock_evt    <= 1'b0;
			retry_evt   <= 1'b0;
			if (frame_start) begin
				start_lock_free <= ~s_lock;
				// a start with lock released is the owner's way in
				owner_access <= ~s_lock;
			end
			unlock_pend <= last_xfer & target_sel_in;
			case (lock_state)
			ST_UNLOCKED: begin
				// lock seen already at the start is ignored
				if (start_pend & start_lock_free & s_lock & target_sel_in) begin
					lock_state <= ST_LOCKED;
					lock_evt   <= 1'b1;
				end
			end
			ST_LOCKED: begin
				if (unlock_pend & ~s_lock & owner_access)
					lock_state <= ST_UNLOCKED;
			end
			default: lock_state <= ST_UNLOCKED;
			endcase
			// non-owner held off while the lock stands
			target_retry_out <= (lock_state == ST_LOCKED) & target_sel_in & s_frame &
				~owner_access & ~frame_start;
			retry_evt  <= (lock_state == ST_LOCKED) & start_pend & target_sel_in &
				~owner_access;
			locked_out <= lock_state == ST_LOCKED;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// master side: lock is never driven, retries are passed on
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			lock_n_oe_out    <= 1'b0;
			master_retry_out <= 1'b0;
		end else begin
			lock_n_oe_out    <= 1'b0;
			master_retry_out <= master_active_in & s_stop & s_devsel & ~s_trdy;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// apb slave: one wait state, read data latched as pready rises, write applied at the next edge
	wire access = psel_in & penable_in & pready_out;
	wire wr     = access & pwrite_in;
	wire rd     = access & ~pwrite_in;
	reg  [31:0] next_rdata;
	reg         next_err;
	always @* begin
		next_rdata = 32'h0;
		next_err   = 1'b0;
		if (paddr_in == `PLP_ADDR_CMD)
			next_rdata = {16'h0, cmd_reg};
		else if (paddr_in == `PLP_ADDR_STAT)
			next_rdata = {16'h0, stat_reg};
		else if (paddr_in == `PLP_ADDR_ICSR)
			next_rdata = {23'h0, icsr_en, 7'h0, icsr_src};
		else if (paddr_in == `PLP_ADDR_EVT)
			next_rdata = {27'h0, evt_reg};
		else if (paddr_in == `PLP_ADDR_MASK)
			next_rdata = {27'h0, mask_reg};
		else if (paddr_in == `PLP_ADDR_STATE)
			next_rdata = {30'h0, lock_state};
		else
			next_err = 1'b1;
	end
	wire [`PLP_EVT_W-1:0] evt_set = {master_retry_out, retry_evt, lock_evt, data_err, addr_err};
	always @(posedge core_clk_in) begin
		if (reset_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0;
			cmd_reg     <= 16'h0;
			stat_reg    <= 16'h0;
			icsr_src    <= 1'b0;
			icsr_en     <= 1'b0;
			evt_reg     <= {`PLP_EVT_W{1'b0}};
			mask_reg    <= {`PLP_EVT_W{1'b0}};
			inta_n_oe_out <= 1'b0;
			irq_out       <= 1'b0;
		end else begin
			pready_out  <= psel_in & penable_in & ~pready_out;
			pslverr_out <= psel_in & penable_in & ~pready_out & next_err;
			if (psel_in & penable_in & ~pready_out)
				prdata_out <= pwrite_in ? 32'h0 : next_rdata;
			if (wr & (paddr_in == `PLP_ADDR_CMD))
				cmd_reg <= pwdata_in[15:0] &
					(16'h1 << `PLP_CMD_PERR_EN | 16'h1 << `PLP_CMD_SERR_EN);
			if (wr & (paddr_in == `PLP_ADDR_MASK))
				mask_reg <= pwdata_in[`PLP_EVT_W-1:0];
			if (wr & (paddr_in == `PLP_ADDR_ICSR))
				icsr_en <= pwdata_in[`PLP_ICSR_EN];
			// write one clears, a new event in the same clock wins
			if (wr & (paddr_in == `PLP_ADDR_STAT)) begin
				if (pwdata_in[`PLP_STAT_DPR]) stat_reg[`PLP_STAT_DPR] <= 1'b0;
				if (pwdata_in[`PLP_STAT_SSE]) stat_reg[`PLP_STAT_SSE] <= 1'b0;
				if (pwdata_in[`PLP_STAT_DPE]) stat_reg[`PLP_STAT_DPE] <= 1'b0;
			end
			if (serr_fire)
				stat_reg[`PLP_STAT_SSE] <= 1'b1;
			if (data_err)
				stat_reg[`PLP_STAT_DPE] <= 1'b1;
			if (data_err & data_master & perr_en)
				stat_reg[`PLP_STAT_DPR] <= 1'b1;
			if (wr & (paddr_in == `PLP_ADDR_ICSR) & pwdata_in[`PLP_ICSR_SRC])
				icsr_src <= 1'b0;
			if (int_event_in)
				icsr_src <= 1'b1;
			// event status clears on read; events in the clearing clock survive, events in the wait state before it are lost
			if (rd & (paddr_in == `PLP_ADDR_EVT))
				evt_reg <= evt_set;
			else
				evt_reg <= evt_reg | evt_set;
			// pci interrupt is the open-drain enable, no fixed bus timing implied
			inta_n_oe_out <= icsr_src & icsr_en;
			irq_out       <= |(evt_reg & mask_reg);
		end
	end
endmodule

// ### rtl/plp_consts.vh
// constants for the pci lock, parity and interrupt block
`ifndef PLP_CONSTS_VH
`define PLP_CONSTS_VH
`define PLP_ADDR_CMD      12'h000
`define PLP_ADDR_STAT     12'h004
`define PLP_ADDR_ICSR     12'h008
`define PLP_ADDR_EVT      12'h00c
`define PLP_ADDR_MASK     12'h010
`define PLP_ADDR_STATE    12'h014
`define PLP_CMD_PERR_EN   6
`define PLP_CMD_SERR_EN   8
`define PLP_STAT_DPR      8
`define PLP_STAT_SSE      14
`define PLP_STAT_DPE      15
`define PLP_ICSR_SRC      0
`define PLP_ICSR_EN       8
`define PLP_EVT_ADDR_PERR 0
`define PLP_EVT_DATA_PERR 1
`define PLP_EVT_LOCKED    2
`define PLP_EVT_RETRY     3
`define PLP_EVT_MRETRY    4
`define PLP_EVT_W         5
`define PLP_SPECIAL_CYCLE 4'h1
`define PLP_PERR_DELAY    2
`define PLP_SERR_CLOCKS   1
`endif

// ### tb/plp_pci_model.sv
// pci bus model: host, masters and targets driving the shared pins
`timescale 1ns/1ps
module plp_pci_model (
	// clock
	input  wire        clk_in,
	// shared pci pins
	output reg  [31:0] ad_out,
	output reg  [3:0]  cbe_n_out,
	output reg         par_out,
	output reg         frame_n_out,
	output reg         irdy_n_out,
	output reg         trdy_n_out,
	output reg         lock_n_out
);
	reg flip;
	initial begin
		{ad_out, cbe_n_out, par_out, flip} = 0;
		{frame_n_out, irdy_n_out, trdy_n_out, lock_n_out} = 4'hf;
	end
	// par trails its lines by a clock; flip spoils one clock on purpose
	always @(posedge clk_in)
		par_out <= ^{ad_out, cbe_n_out, flip};
	// ad never holds still, so a stale value cannot pass for fresh data
	task cyc(input [3:0] pins, input [3:0] cbe, input bad);
		begin
			@(posedge clk_in);
			{frame_n_out, irdy_n_out, trdy_n_out, lock_n_out} <= pins;
			cbe_n_out <= cbe;
			ad_out    <= {ad_out[30:0], ~ad_out[31]};
			flip      <= bad;
		end
	endtask
endmodule

// ### tb/plp_core_assertions.sv
// port checks for the pci lock, parity and interrupt block
`timescale 1ns/1ps
module plp_core_assertions (
	input wire core_clk_in,
	input wire reset_in,
	input wire pwrite_in,
	input wire pready_out,
	input wire frame_n_in,
	input wire irdy_n_in,
	input wire trdy_n_in,
	input wire lock_n_in,
	input wire inta_n_oe_out,
	input wire serr_n_oe_out,
	input wire perr_n_out,
	input wire perr_n_oe_out,
	input wire lock_n_oe_out,
	input wire target_retry_out,
	input wire locked_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	// pins reach the logic two clocks late, hence the depths below
	lock_never_a: assert property (!lock_n_oe_out)
		else $error("lock pin driven");
	serr_pulse_a: assert property (serr_n_oe_out |=> !serr_n_oe_out)
		else $error("serr longer than one clock");
	serr_cause_a: assert property (serr_n_oe_out |-> $past(frame_n_in, 5) && !$past(frame_n_in, 4))
		else $error("serr without frame start");
	perr_drive_a: assert property (!perr_n_out |-> perr_n_oe_out)
		else $error("perr low while not driven");
	perr_cause_a: assert property (!perr_n_out |-> $past(!irdy_n_in && !trdy_n_in, 4))
		else $error("perr not two clocks after a transfer");
	retry_lock_a: assert property (target_retry_out |-> locked_out)
		else $error("retry while unlocked");
	lock_enter_a: assert property ($rose(locked_out) |-> $past(lock_n_in, 5) && !$past(lock_n_in, 4))
		else $error("lock entered without lock sequence");
	inta_clear_a: assert property ($fell(inta_n_oe_out) |-> $past(pwrite_in && pready_out, 2))
		else $error("inta released without a write");
endmodule
bind plp_core plp_core_assertions u_chk (.core_clk_in(core_clk_in), .reset_in(reset_in),
	.pwrite_in(pwrite_in), .pready_out(pready_out), .frame_n_in(frame_n_in),
	.irdy_n_in(irdy_n_in), .trdy_n_in(trdy_n_in), .lock_n_in(lock_n_in),
	.inta_n_oe_out(inta_n_oe_out), .serr_n_oe_out(serr_n_oe_out), .perr_n_out(perr_n_out),
	.perr_n_oe_out(perr_n_oe_out), .lock_n_oe_out(lock_n_oe_out),
	.target_retry_out(target_retry_out), .locked_out(locked_out));

// ### tb/testbench.sv
// self-checking bench for the pci lock, parity and interrupt block
`timescale 1ns/1ps
`include "plp_consts.vh"
module testbench;
	reg          clk = 0;
	reg          rst = 1;
	reg          psel = 0;
	reg          pen = 0;
	reg          pwr = 0;
	reg          iev = 0;
	reg  [11:0]  addr = 0;
	reg  [31:0]  wd = 0;
	reg  [3:0]   ctx = 0;
	wire [31:0]  rd, ad;
	wire [3:0]   cbe;
	wire         rdy, err, par, fr, ir, tr, lk, inta, serr, perr, tret, lkd, irq;
	logic [31:0] rv;
	integer      bad_count = 0;
	integer      n_compared = 0;
	integer      np = 0;
	integer      nr = 0;
	integer      ns = 0;
	integer      k;
	logic [3:0]  cx [6] = '{4'hc, 4'h3, 4'h3, 4'hc, 4'h8, 4'hc};
	logic [3:0]  cm [6] = '{4'h7, 4'h6, 4'h6, 4'h1, 4'h6, 4'h7};
	logic [31:0] cr [6] = '{32'h140, 32'h140, 32'h100, 32'h140, 32'h140, 32'h140};
	logic [31:0] st [6] = '{32'h8000, 32'h8100, 32'h8000, 32'h8000, 32'h0, 32'h0};
	logic [5:0]  pe = 6'h03;
	logic [5:0]  nt = 6'h20;
	always #20 clk = ~clk;
	plp_pci_model u_bus (.clk_in(clk), .ad_out(ad), .cbe_n_out(cbe), .par_out(par),
		.frame_n_out(fr), .irdy_n_out(ir), .trdy_n_out(tr), .lock_n_out(lk));
	plp_core u_plp_core (.core_clk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wd), .prdata_out(rd), .pready_out(rdy),
		.pslverr_out(err), .ad_in(ad), .cbe_n_in(cbe), .par_in(par), .frame_n_in(fr),
		.irdy_n_in(ir), .trdy_n_in(tr), .stop_n_in(1'b1), .devsel_n_in(tr), .lock_n_in(lk),
		.target_sel_in(ctx[3]), .target_write_in(ctx[2]), .master_active_in(ctx[1]),
		.master_read_in(ctx[0]), .int_event_in(iev), .inta_n_oe_out(inta),
		.serr_n_oe_out(serr), .perr_n_out(perr), .perr_n_oe_out(), .lock_n_oe_out(),
		.target_retry_out(tret), .master_retry_out(), .locked_out(lkd), .irq_out(irq));
	task stop_test;
		begin
			if (bad_count == 0 && n_compared > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] s);
		begin
			n_compared = n_compared + 1;
			if (s !== e) begin
				bad_count = bad_count + 1;
				$display("FAIL %s expected %h seen %h", nm, e, s);
			end
		end
	endtask
	// one apb transfer; rv takes read data, or dead when pslverr is set
	task apb(input w, input [11:0] a, input [31:0] d);
		integer i;
		begin
			@(posedge clk);
			psel <= 1;
			pwr <= w;
			addr <= a;
			wd <= d;
			@(posedge clk);
			pen <= 1;
			i = 0;
			do begin
				@(posedge clk);
				i = i + 1;
			end while (rdy !== 1'b1 && i < 20);
			if (rdy !== 1'b1) begin
				bad_count = bad_count + 1;
				stop_test;
			end
			rv = err ? 32'hdead : rd;
			psel <= 0;
			pen <= 0;
		end
	endtask
	task rdc(input [11:0] a, input [31:0] e);
		begin
			apb(0, a, 32'h0);
			chk("reg", e, rv);
		end
	endtask
	// n bus clocks, counting perr, retry and serr sightings
	task step(input [3:0] p, input [3:0] c, input b, input integer n);
		integer j;
		begin
			for (j = 0; j < n; j = j + 1) begin
				u_bus.cyc(p, c, b);
				np = np + (perr === 1'b0);
				nr = nr + (tret === 1'b1);
				ns = ns + (serr === 1'b1);
			end
		end
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		apb(1, `PLP_ADDR_CMD, 32'h140);
		rdc(`PLP_ADDR_CMD, 32'h140);
		rdc(12'h020, 32'hdead);
		step(4'b0111, 4'h7, 1, 1);
		step(4'b1001, 4'h0, 0, 1);
		step(4'b1111, 4'h0, 0, 6);
		chk("serr", 1, ns);
		chk("irq", 0, {31'h0, irq});
		apb(1, `PLP_ADDR_MASK, 32'h1);
		step(4'b1111, 4'h0, 0, 2);
		chk("irq", 1, {31'h0, irq});
		rdc(`PLP_ADDR_EVT, 32'h1);
		step(4'b1111, 4'h0, 0, 2);
		chk("irq", 0, {31'h0, irq});
		apb(1, `PLP_ADDR_STAT, 32'h0);
		rdc(`PLP_ADDR_STAT, 32'h4000);
		apb(1, `PLP_ADDR_STAT, 32'h4000);
		rdc(`PLP_ADDR_STAT, 32'h0);
		for (k = 0; k < 6; k = k + 1) begin
			apb(1, `PLP_ADDR_CMD, cr[k]);
			ctx <= cx[k];
			np = 0;
			step(4'b0111, cm[k], 0, 1);
			step({2'b10, nt[k], 1'b1}, 4'h0, 1, 1);
			step(4'b1111, 4'h0, 0, 6);
			ctx <= 0;
			chk("perr", {31'h0, pe[k]}, np);
			rdc(`PLP_ADDR_STAT, st[k]);
			apb(1, `PLP_ADDR_STAT, 32'hc100);
		end
		ctx <= 4'hc;
		step(4'b0111, 4'h7, 0, 1);
		step(4'b0000, 4'h0, 0, 1);
		step(4'b1000, 4'h0, 0, 1);
		step(4'b1110, 4'h0, 0, 6);
		chk("locked", 1, {31'h0, lkd});
		nr = 0;
		step(4'b0110, 4'h7, 0, 6);
		step(4'b1110, 4'h0, 0, 4);
		chk("retry", 1, {31'h0, nr != 0});
		nr = 0;
		step(4'b0111, 4'h7, 0, 1);
		step(4'b1001, 4'h0, 0, 1);
		step(4'b1111, 4'h0, 0, 6);
		chk("retry", 0, nr);
		chk("locked", 0, {31'h0, lkd});
		step(4'b1110, 4'h0, 0, 2);
		step(4'b0110, 4'h7, 0, 1);
		step(4'b1000, 4'h0, 0, 1);
		step(4'b1110, 4'h0, 0, 6);
		chk("locked", 0, {31'h0, lkd});
		ctx <= 0;
		apb(1, `PLP_ADDR_ICSR, 32'h100);
		iev <= 1;
		@(posedge clk);
		iev <= 0;
		step(4'b1111, 4'h0, 0, 20);
		chk("inta", 1, {31'h0, inta});
		apb(1, `PLP_ADDR_ICSR, 32'h101);
		step(4'b1111, 4'h0, 0, 3);
		chk("inta", 0, {31'h0, inta});
		stop_test;
	end
endmodule
